// [rtl/dma_ctl.sv]
// The register offsets and strobed register access were left to the implementer.
`include "dma_ctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dma_ctl #(
    parameter int COUNT_W = 24
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_STANDBY,
    // register port
    input wire dma_ctl_pkg::bus_req_s I_BUS,
    output logic [31:0] O_RDATA,
    // request and transfer progress
    input wire logic I_REQUEST,
    input wire logic I_COUNT_ZERO,
    input wire logic I_NMI,
    input wire logic I_ADDR_ERR,
    input wire logic I_BEAT_DONE,
    // transfer control out
    output logic O_BEAT_REQ,
    output dma_ctl_pkg::mode_s O_MODE,
    output logic O_ACTIVE,
    // interrupt
    output logic O_IRQ,
    output logic [7:0] O_VECTOR
);
    import dma_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register map, word offsets on the 4-bit byte address
    //   channel control  : enables, modes, end flag, auto request
    //   vector number    : eight bits, upper bits read zero
    //   global operation : master enable, nmi flag, address error flag
    //   irq status       : bit0 transfer end, bit1 abort, write one clears
    //   irq mask         : same layout as status
    // the mask sits at the halfword offset 4'hE because the address is four bits
    // wide and the four word offsets are already taken
    //
    // channel control bits held here
    //   bit0 channel enable
    //   bit1 transfer end flag, set by hardware only
    //   bit2 end interrupt enable
    //   bit3 single address select
    //   bit4 burst bus select
    //   bit5 request polarity
    //   bit6 request detect select, edge when one
    //   bit9 auto request
    // every other bit reads zero and ignores writes
    //
    // request detection
    //   level mode looks at the pin every cycle
    //   edge mode compares the pin with its value one cycle back
    //   the delay flop resets low, so a high pin at release reads as a
    //   rising edge; software should enable edge mode after the pin has
    //   settled to its idle level
    //
    // transfer flow
    //   idle : waits for the start gate and a request or auto mode
    //   xfer : datapath moves units while the beat request stands
    //   done : one cycle after the last unit, then back to idle
    // in cycle-steal mode the machine drops to idle after each unit,
    // so the bus is handed back between units; in burst mode it stays
    // in xfer until the count runs out or an abort comes
    //
    // start gate
    //   channel enable and master enable both set
    //   nmi flag, address error flag and end flag all clear
    // the gate is checked only from idle; an abort while in xfer
    // drops the machine to idle without touching the end flag
    //
    // abort sources
    //   channel enable cleared by software
    //   master enable cleared by software
    //   nmi input or its sticky flag
    //   address error input or its sticky flag
    // an abort in the same cycle as the last unit wins: the end flag
    // stays clear, the abort status bit is raised instead
    //
    // end flag clearing
    //   software must read the control word while the flag is one,
    //   then write the control word with the flag bit at zero
    //   any other control write between the two forgets the read
    //   a write of one to the flag bit never sets it
    //   when hardware sets the flag in the same cycle as the clear
    //   write, the set wins so no finished transfer is lost
    //
    // interrupt output
    //   end flag and end interrupt enable, or any unmasked status bit
    //   registered, so it follows its sources by one cycle
    //   it stays high until the source is cleared
    //
    // vector number
    //   kept through reset and standby, unknown until first written
    //   software keeps the top bit at zero
    //   the output copy reads zero during reset and standby
    //
    // standby
    //   clears control, global, status, mask and the machine like reset
    //   leaves the vector number and the read data register alone
    //
    // read data
    //   registered, valid only in the cycle after the read strobe
    //   zero in every other cycle so a shared bus can or it in
    //
    // limitations
    //   burst mode with level detection is not guarded here; the
    //   machine simply keeps running until the count runs out or an abort comes, whatever the level does
    //   the transfer count lives in the datapath; only its zero
    //   indication and the unit-done pulse come in here
    //   one channel per instance; a second channel is a second copy
    //
    // hazards
    //   the nmi and address error inputs set their flags even when
    //   no transfer runs, which blocks the next start until software
    //   writes zero to the flag in the global register
    //   clearing master enable stops this instance's one channel, even in the middle of a transfer
    //   the abort status bit is set only when a transfer was running
    ////////////////////////////////////////////////////////////////////
    logic [15:0] ctrl_r;
    logic [`VEC_W-1:0] vec_r;
    logic [2:0] glob_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic end_seen_r;
    logic req_d_r;
    logic req_hit;
    logic may_run;
    logic set_end;
    logic abort;
    logic end_wr_clear;
    xfer_state_e state_r;
    xfer_state_e state_nxt;

    // request detection
    // level or edge
    always_comb begin
        if (ctrl_r[`BIT_DSEL]) begin
            req_hit = ctrl_r[`BIT_POL] ? (I_REQUEST & ~req_d_r)
                                       : (~I_REQUEST & req_d_r);
        end else begin
            req_hit = ctrl_r[`BIT_POL] ? I_REQUEST : ~I_REQUEST;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            req_d_r <= 1'b0;
        end else begin
            req_d_r <= I_REQUEST;
        end
    end

    // start gating
    // gate start
    assign may_run = ctrl_r[`BIT_CH_EN] & glob_r[`BIT_MASTER]
                   & ~glob_r[`BIT_NMI] & ~glob_r[`BIT_AERR]
                   & ~ctrl_r[`BIT_END];
    assign abort = ~ctrl_r[`BIT_CH_EN] | ~glob_r[`BIT_MASTER]
                 | I_NMI | I_ADDR_ERR | glob_r[`BIT_NMI] | glob_r[`BIT_AERR];
    assign set_end = (state_r == ST_XFER) & I_BEAT_DONE & I_COUNT_ZERO
                   & ~abort;

    ////////////////////////////////////////////////////////////////////
    // transfer state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (may_run && (ctrl_r[`BIT_AUTO] || req_hit)) begin
                    state_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                if (abort) begin
                    state_nxt = ST_IDLE;
                end else if (I_BEAT_DONE) begin
                    if (I_COUNT_ZERO) begin
                        state_nxt = ST_DONE;
                    end else if (!ctrl_r[`BIT_BURST]) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // transfer outputs
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            O_BEAT_REQ <= 1'b0;
            O_ACTIVE <= 1'b0;
            O_MODE <= '0;
        end else begin
            O_BEAT_REQ <= (state_nxt == ST_XFER);
            O_ACTIVE <= (state_nxt == ST_XFER);
            O_MODE.burst <= ctrl_r[`BIT_BURST];
            O_MODE.single_addr <= ctrl_r[`BIT_SINGLE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clear needs prior read of one
    assign end_wr_clear = I_BUS.wr && I_BUS.addr == `ADDR_CHAN_CTRL
                        && !I_BUS.wdata[`BIT_END] && end_seen_r;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            end_seen_r <= 1'b0;
        end else if (I_BUS.rd && I_BUS.addr == `ADDR_CHAN_CTRL) begin
            end_seen_r <= ctrl_r[`BIT_END];
        end else if (I_BUS.wr && I_BUS.addr == `ADDR_CHAN_CTRL) begin
            end_seen_r <= 1'b0;
        end
    end

    // channel control register
    // reset and standby clear
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            ctrl_r <= `CTRL_RST;
        end else begin
            if (I_BUS.wr && I_BUS.addr == `ADDR_CHAN_CTRL) begin
                ctrl_r <= I_BUS.wdata[15:0] & `CTRL_WMASK;
            end
            if (set_end) begin
                ctrl_r[`BIT_END] <= 1'b1;
            end else if (end_wr_clear) begin
                ctrl_r[`BIT_END] <= 1'b0;
            end else begin
                ctrl_r[`BIT_END] <= ctrl_r[`BIT_END];
            end
        end
    end

    // global register and abort flags
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            glob_r <= 3'h0;
        end else begin
            if (I_BUS.wr && I_BUS.addr == `ADDR_GLOBAL) begin
                glob_r[`BIT_MASTER] <= I_BUS.wdata[`BIT_MASTER];
                glob_r[`BIT_NMI] <= glob_r[`BIT_NMI] & I_BUS.wdata[`BIT_NMI];
                glob_r[`BIT_AERR] <= glob_r[`BIT_AERR]
                                   & I_BUS.wdata[`BIT_AERR];
            end
            if (I_NMI) begin
                glob_r[`BIT_NMI] <= 1'b1;
            end
            if (I_ADDR_ERR) begin
                glob_r[`BIT_AERR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_BUS.wr && I_BUS.addr == `ADDR_VECTOR) begin
            vec_r <= I_BUS.wdata[`VEC_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky status: bit0 transfer end, bit1 abort; write one clears
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
        end else begin
            if (I_BUS.wr && I_BUS.addr == `ADDR_IRQ_MASK) begin
                mask_r <= I_BUS.wdata[1:0];
            end
            stat_r[0] <= set_end
                       | (stat_r[0] & ~(I_BUS.wr
                       && I_BUS.addr == `ADDR_IRQ_STAT
                       && I_BUS.wdata[0]));
            stat_r[1] <= (state_r == ST_XFER && abort)
                       | (stat_r[1] & ~(I_BUS.wr
                       && I_BUS.addr == `ADDR_IRQ_STAT
                       && I_BUS.wdata[1]));
        end
    end

    // interrupt and vector outputs
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || I_STANDBY) begin
            O_IRQ <= 1'b0;
            O_VECTOR <= 8'h00;
        end else begin
            O_IRQ <= (ctrl_r[`BIT_END] & ctrl_r[`BIT_IE])
                   | (|(stat_r & mask_r));
            O_VECTOR <= vec_r;
        end
    end

    // read data, one cycle after strobe
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_RDATA <= 32'h0000_0000;
        end else if (I_BUS.rd) begin
            case (I_BUS.addr)
                `ADDR_CHAN_CTRL: O_RDATA <= {16'h0000, ctrl_r};
                `ADDR_VECTOR: O_RDATA <= {24'h00_0000, vec_r};
                `ADDR_GLOBAL: O_RDATA <= {29'h0000_0000, glob_r};
                `ADDR_IRQ_STAT: O_RDATA <= {30'h0000_0000, stat_r};
                default: begin
                    if (I_BUS.addr == `ADDR_IRQ_MASK) begin
                        O_RDATA <= {30'h0000_0000, mask_r};
                    end else begin
                        O_RDATA <= 32'h0000_0000;
                    end
                end
            endcase
        end else begin
            O_RDATA <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// [rtl/dma_ctl_defines.svh]
`ifndef DMA_CTL_DEFINES_SVH
`define DMA_CTL_DEFINES_SVH
`define ADDR_CHAN_CTRL 4'h0
`define ADDR_VECTOR 4'h4
`define ADDR_GLOBAL 4'h8
`define ADDR_IRQ_STAT 4'hC
`define ADDR_IRQ_MASK 4'hE
`define BIT_CH_EN 0
`define BIT_END 1
`define BIT_IE 2
`define BIT_SINGLE 3
`define BIT_BURST 4
`define BIT_POL 5
`define BIT_DSEL 6
`define BIT_AUTO 9
`define BIT_MASTER 0
`define BIT_NMI 1
`define BIT_AERR 2
`define CTRL_RST 16'h0000
`define CTRL_WMASK 16'h027D
`define VEC_W 8
`endif

// [rtl/dma_ctl_pkg.sv]
package dma_ctl_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic single_addr;
        logic burst;
    } mode_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_DONE = 3'b100
    } xfer_state_e;
endpackage

// [dv/dma_ctl_props.sv]
`timescale 1ns/100ps
`default_nettype none
module dma_ctl_props (
    // clock, reset, bus
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_STANDBY,
    input wire dma_ctl_pkg::bus_req_s I_BUS,
    input wire logic [31:0] O_RDATA,
    // transfer
    input wire logic I_NMI,
    input wire logic I_ADDR_ERR,
    input wire logic O_BEAT_REQ,
    input wire logic O_ACTIVE,
    input wire dma_ctl_pkg::mode_s O_MODE
);
    import dma_ctl_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N || I_STANDBY);
    // a write to the control word
    sequence ctrl_wr;
        I_BUS.wr && I_BUS.addr == 4'h0;
    endsequence
    // a control write followed by a quiet cycle
    sequence ctrl_wr_quiet;
        ctrl_wr ##1 !I_BUS.wr;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    active_mirror_a: assert property (O_ACTIVE == O_BEAT_REQ)
        else $error("active differs from beat request");
    mode_copy_a: assert property (ctrl_wr_quiet |-> ##2
        O_MODE == {$past(I_BUS.wdata[3], 3), $past(I_BUS.wdata[4], 3)})
        else $error("mode outputs do not follow control bits");
    rdata_idle_a: assert property (!$past(I_BUS.rd) |-> O_RDATA == 32'h0)
        else $error("read data not zero outside a read");
    vec_upper_a: assert property ($past(I_BUS.rd && I_BUS.addr == 4'h4)
        |-> O_RDATA[31:8] == 24'h0)
        else $error("vector upper bits not zero");
    ctrl_upper_a: assert property ($past(I_BUS.rd && I_BUS.addr == 4'h0)
        |-> O_RDATA[31:10] == 22'h0 && O_RDATA[8:7] == 2'h0)
        else $error("unused control bits not zero");
    nmi_stop_a: assert property (I_NMI |-> ##[1:2] !O_BEAT_REQ)
        else $error("transfer runs on after nmi");
    aerr_stop_a: assert property (I_ADDR_ERR |-> ##[1:2] !O_BEAT_REQ)
        else $error("transfer runs on after address error");
    en_stop_a: assert property (ctrl_wr and !I_BUS.wdata[0]
        |-> ##[1:3] !O_BEAT_REQ)
        else $error("transfer runs on after enable cleared");
endmodule
bind dma_ctl dma_ctl_props dma_ctl_props_i (.I_CLK, .I_RST_N, .I_STANDBY,
    .I_BUS, .O_RDATA, .I_NMI, .I_ADDR_ERR, .O_BEAT_REQ, .O_ACTIVE, .O_MODE);
`default_nettype wire

// [dv/far_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module far_dev (
    // clock and count load
    input wire logic clk,
    input wire logic load,
    input wire logic [7:0] beats,
    // channel side
    input wire logic beat_req,
    output logic done = 1'b0,
    output logic zero
);
    logic [7:0] left_r = 8'h00;
    logic [1:0] gap_r = 2'h0;
    // one unit finishes every fourth cycle while the channel asks
    always @(posedge clk) begin
        gap_r <= beat_req ? gap_r + 2'h1 : 2'h0;
        done <= beat_req && gap_r == 2'h3;
        if (load)
            left_r <= beats;
        else if (done)
            left_r <= left_r - 8'h01;
    end
    assign zero = done && left_r == 8'h01;
endmodule
`default_nettype wire

// [dv/dma_ctl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module dma_ctl_tb;
    import dma_ctl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, stby = 1'b0, req = 1'b1;
    logic nmi = 1'b0, aerr = 1'b0, load = 1'b1;
    logic [7:0] beats = 8'h03;
    bus_req_s bus = '0;
    logic [31:0] rdata;
    logic done, zero, beat, active, irq;
    mode_s mode;
    logic [7:0] vec;
    int bad_count = 0, checks = 0, cyc = 0;
    dma_ctl dma_ctl_i (.I_CLK(clk), .I_RST_N(rst_n), .I_STANDBY(stby),
        .I_BUS(bus), .O_RDATA(rdata), .I_REQUEST(req), .I_COUNT_ZERO(zero),
        .I_NMI(nmi), .I_ADDR_ERR(aerr), .I_BEAT_DONE(done),
        .O_BEAT_REQ(beat), .O_MODE(mode), .O_ACTIVE(active), .O_IRQ(irq),
        .O_VECTOR(vec));
    far_dev far_dev_i (.clk(clk), .load(load), .beats(beats),
        .beat_req(beat), .done(done), .zero(zero));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp, input string w);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, string w);
        @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 chk(rdata, e, w);
    endtask
    task automatic wait_for(ref logic s, input logic v, input string w);
        for (int n = 0; n < 60 && s !== v; n++) begin
            @(posedge clk) #1;
        end
        chk({31'h0, s}, {31'h0, v}, w);
    endtask
    task automatic close_out();
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // clock and hang guard
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        load <= 1'b0;
        rd(4'h0, 32'h0, "ctrl reset");
        rd(4'h2, 32'h0, "unmapped");
        wr(4'h4, 32'h7F);
        rd(4'h4, 32'h7F, "vector");
        chk({24'h0, vec}, 32'h7F, "vector out");
        wr(4'h0, 32'h18);
        @(posedge clk) #1 chk({30'h0, mode}, 32'h3, "mode");
        // auto burst run ends on zero count
        wr(4'h8, 32'h1);
        wr(4'h0, 32'h215);
        wait_for(beat, 1'b1, "auto start");
        wait_for(irq, 1'b1, "end irq");
        rd(4'h0, 32'h217, "end flag");
        rd(4'hC, 32'h1, "status end");
        wr(4'hC, 32'h1);
        wr(4'h0, 32'h217);
        wr(4'h0, 32'h215);
        rd(4'h0, 32'h217, "flag kept");
        chk({31'h0, beat}, 32'h0, "blocked");
        chk({31'h0, active}, 32'h0, "blocked active");
        wr(4'h0, 32'h214);
        rd(4'h0, 32'h214, "flag cleared");
        chk({31'h0, irq}, 32'h0, "irq dropped");
        // low level request, nmi abort
        beats <= 8'hFF;
        load <= 1'b1;
        wr(4'h0, 32'h01);
        load <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, beat}, 32'h0, "high ignored");
        req <= 1'b0;
        wait_for(beat, 1'b1, "low level");
        @(posedge clk) nmi <= 1'b1;
        @(posedge clk) nmi <= 1'b0;
        wait_for(beat, 1'b0, "nmi stop");
        rd(4'h0, 32'h01, "no flag");
        rd(4'h8, 32'h3, "nmi flag");
        rd(4'hC, 32'h2, "status abort");
        wr(4'hE, 32'h2);
        @(posedge clk) #1 chk({31'h0, irq}, 32'h1, "abort irq");
        wr(4'hC, 32'h2);
        wr(4'hE, 32'h0);
        rd(4'hC, 32'h0, "status cleared");
        wr(4'h8, 32'h1);
        wait_for(beat, 1'b1, "resume");
        wr(4'h0, 32'h00);
        wait_for(beat, 1'b0, "enable clear");
        // rising edge request, address error abort
        wr(4'h0, 32'h61);
        repeat (3) @(posedge clk);
        chk({31'h0, beat}, 32'h0, "low no edge");
        req <= 1'b1;
        wait_for(beat, 1'b1, "rising edge");
        @(posedge clk) aerr <= 1'b1;
        @(posedge clk) aerr <= 1'b0;
        wait_for(beat, 1'b0, "aerr stop");
        rd(4'h0, 32'h61, "aerr no flag");
        // standby clears control, keeps vector
        @(posedge clk) stby <= 1'b1;
        @(posedge clk) stby <= 1'b0;
        rd(4'h0, 32'h0, "standby ctrl");
        rd(4'h4, 32'h7F, "standby vector");
        close_out();
    end
endmodule
`default_nettype wire
